// [pfbw_defs.svh]
// constants for the program flash block writer
`ifndef PFBW_DEFS_SVH
`define PFBW_DEFS_SVH
`define PFBW_OFF_CTRL 12'h000
`define PFBW_OFF_PTR 12'h004
`define PFBW_OFF_LATCH 12'h008
`define PFBW_OFF_STAT 12'h00C
`define PFBW_OFF_MASK 12'h010
`define PFBW_OFF_UNLOCK 12'h014
`define PFBW_OFF_PROT 12'h018
`define PFBW_CTRL_WR 0
`define PFBW_CTRL_WRITE_ENABLE_BIT 1
`define PFBW_CTRL_PMEM 2
`define PFBW_CTRL_WRERR 3
`define PFBW_ST_DONE 0
`define PFBW_ST_ERR 1
`define PFBW_UNLOCK_A 8'h55
`define PFBW_UNLOCK_B 8'hAA
`define PFBW_LATCH_RST 8'hFF
`define PFBW_PROG_TIME_NS 2000000
`define PFBW_CLK_PERIOD_NS 40
`define PFBW_PROG_CYC ((`PFBW_PROG_TIME_NS + `PFBW_CLK_PERIOD_NS - 1) / `PFBW_CLK_PERIOD_NS)
`define PFBW_RESP_OKAY 2'b00
`define PFBW_RESP_SLVERR 2'b10
`endif

// [pfbw_pkg.sv]
// types for the program flash block writer
package pfbw_pkg;
   typedef enum logic [1:0] {PFBW_IDLE, PFBW_PROG, PFBW_DONE} pfbw_state_t;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } pfbw_wreq_t;
endpackage

// [pfbw_prog_timer.sv]
// internal programming timer for one block write
module pfbw_prog_timer
   import pfbw_pkg::*;
#(
   parameter int CYCLES = 50000
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   output logic expired
);
   initial begin
      if (CYCLES < 2) $error("programming time must be at least two cycles");
   end
   logic [31:0] cnt_r;
   logic run_r;
   // count down while a write runs; loaded two short so the pulse lands on the last held cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 32'h0000_0000;
         run_r <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (start) begin
            cnt_r <= 32'(CYCLES - 2);
            run_r <= 1'b1;
         end else if (run_r) begin
            if (cnt_r == 32'h0000_0000) begin
               run_r <= 1'b0;
               expired <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 32'h0000_0001;
            end
         end
      end
   end
endmodule

// [pfbw_top.sv]
// program flash block writer with axi4-lite register slave
`include "pfbw_defs.svh"
module pfbw_top
   import pfbw_pkg::*;
#(
   parameter int BLOCK_BYTES = 64,
   parameter int PTR_W = 16,
   parameter int PROG_CYC = `PFBW_PROG_CYC
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [11:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [11:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic CORE_HOLD,
   output logic FLASH_WE,
   output logic [PTR_W-1:0] FLASH_ADDR,
   output logic [7:0] FLASH_DATA,
   output logic IRQ
);
   localparam int LW = $clog2(BLOCK_BYTES);
   initial begin
      if (BLOCK_BYTES < 2 || (BLOCK_BYTES & (BLOCK_BYTES - 1)) != 0)
         $error("block size must be a power of two");
      if (PTR_W <= LW || PTR_W > 24) $error("pointer width unsupported");
      if (PROG_CYC <= BLOCK_BYTES) $error("programming time shorter than block stream");
   end

   logic [7:0] latch_r [BLOCK_BYTES];
   logic [PTR_W-1:0] table_pointer_r;
   logic [PTR_W-1:0] prot_base_r;
   logic write_enable_bit_r, pmem_sel_r, wr_r, write_error_flag_r;
   logic [1:0] sts_r, mask_r;
   logic unlock_a_r;
   pfbw_state_t state_r;
   logic [LW:0] prog_idx_r;
   logic timer_start, timer_done;

   // write channel capture, address and data in either order
   pfbw_wreq_t wreq_r;
   logic aw_have_r, w_have_r;
   logic wfire;
   assign wfire = aw_have_r && w_have_r && !S_AXI_BVALID;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a[11:2] == off[11:2];
   endfunction

   // aw/w handshakes and write response
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY <= 1'b1;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         wreq_r <= '0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `PFBW_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            wreq_r.addr <= S_AXI_AWADDR;
            aw_have_r <= 1'b1;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            wreq_r.data <= S_AXI_WDATA;
            wreq_r.strb <= S_AXI_WSTRB;
            w_have_r <= 1'b1;
            S_AXI_WREADY <= 1'b0;
         end
         if (wfire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= known(wreq_r.addr) ? `PFBW_RESP_OKAY : `PFBW_RESP_SLVERR;
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
         end
      end
   end

   function automatic logic known(input logic [11:0] a);
      return hit(a, `PFBW_OFF_CTRL) || hit(a, `PFBW_OFF_PTR) || hit(a, `PFBW_OFF_LATCH)
         || hit(a, `PFBW_OFF_STAT) || hit(a, `PFBW_OFF_MASK) || hit(a, `PFBW_OFF_UNLOCK)
         || hit(a, `PFBW_OFF_PROT);
   endfunction

   logic wr_ctrl, wr_ptr, wr_latch, wr_unlk, lane0;
   assign lane0 = wreq_r.strb[0];
   assign wr_ctrl = wfire && lane0 && hit(wreq_r.addr, `PFBW_OFF_CTRL);
   assign wr_ptr = wfire && hit(wreq_r.addr, `PFBW_OFF_PTR);
   assign wr_latch = wfire && lane0 && hit(wreq_r.addr, `PFBW_OFF_LATCH);
   assign wr_unlk = wfire && lane0 && hit(wreq_r.addr, `PFBW_OFF_UNLOCK);

   // protected or invalid when below the protect base
   logic bad_addr;
   assign bad_addr = table_pointer_r < prot_base_r;
   logic go;
   // start needs program select, enable and unlock pair
   assign go = wr_unlk && unlock_a_r && wreq_r.data[7:0] == `PFBW_UNLOCK_B
      && write_enable_bit_r && pmem_sel_r && state_r == PFBW_IDLE;

   // table pointer and protect base
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         table_pointer_r <= '0;
         prot_base_r <= '0;
      end else begin
         if (wr_ptr) table_pointer_r <= wreq_r.data[PTR_W-1:0];
         if (wfire && hit(wreq_r.addr, `PFBW_OFF_PROT)) prot_base_r <= wreq_r.data[PTR_W-1:0];
      end
   end

   // control bits, unlock sequence
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         write_enable_bit_r <= 1'b0;
         pmem_sel_r <= 1'b0;
         unlock_a_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            write_enable_bit_r <= wreq_r.data[`PFBW_CTRL_WRITE_ENABLE_BIT];
            pmem_sel_r <= wreq_r.data[`PFBW_CTRL_PMEM];
         end
         if (wr_unlk) unlock_a_r <= wreq_r.data[7:0] == `PFBW_UNLOCK_A;
         else if (wfire) unlock_a_r <= 1'b0;
      end
   end

   // no byte path to flash, only block start
   // duration set by the internal timer
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         state_r <= PFBW_IDLE;
         wr_r <= 1'b0;
         write_error_flag_r <= 1'b0;
         prog_idx_r <= '0;
      end else begin
         if (wr_ctrl && !wreq_r.data[`PFBW_CTRL_WRERR]) write_error_flag_r <= 1'b0;
         unique case (state_r)
            PFBW_IDLE: begin
               if (go) begin
                  if (bad_addr) begin
                     write_error_flag_r <= 1'b1;
                     wr_r <= 1'b0;
                  end else begin
                     wr_r <= 1'b1;
                     prog_idx_r <= '0;
                     state_r <= PFBW_PROG;
                  end
               end
            end
            PFBW_PROG: begin
               if (prog_idx_r < (LW+1)'(BLOCK_BYTES)) prog_idx_r <= prog_idx_r + 1'b1;
               if (timer_done) state_r <= PFBW_DONE;
            end
            PFBW_DONE: begin
               wr_r <= 1'b0;
               state_r <= PFBW_IDLE;
            end
         endcase
      end
   end

   assign timer_start = state_r == PFBW_IDLE && go && !bad_addr;
   pfbw_prog_timer #(.CYCLES(PROG_CYC)) u_timer (
      .clk(CORE_CLK),
      .rst(RST),
      .start(timer_start),
      .expired(timer_done)
   );

   // core held for the whole long write
   // held core sees one instruction cycle
   always_ff @(posedge CORE_CLK) begin
      if (RST) CORE_HOLD <= 1'b0;
      else CORE_HOLD <= timer_start || (state_r == PFBW_PROG && !timer_done);
   end

   // flash byte stream during programming
   // ones-only bytes are not strobed
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         FLASH_WE <= 1'b0;
         FLASH_ADDR <= '0;
         FLASH_DATA <= `PFBW_LATCH_RST;
      end else if (state_r == PFBW_PROG && prog_idx_r < (LW+1)'(BLOCK_BYTES)) begin
         FLASH_WE <= latch_r[prog_idx_r[LW-1:0]] != `PFBW_LATCH_RST;
         FLASH_ADDR <= {table_pointer_r[PTR_W-1:LW], prog_idx_r[LW-1:0]};
         FLASH_DATA <= latch_r[prog_idx_r[LW-1:0]];
      end else begin
         FLASH_WE <= 1'b0;
      end
   end

   // holding latches
   // FFh at reset and after each write
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         for (int i = 0; i < BLOCK_BYTES; i++) latch_r[i] <= `PFBW_LATCH_RST;
      end else if (state_r == PFBW_DONE) begin
         for (int i = 0; i < BLOCK_BYTES; i++) latch_r[i] <= `PFBW_LATCH_RST;
      end else if (wr_latch && state_r == PFBW_IDLE) begin
         latch_r[table_pointer_r[LW-1:0]] <= wreq_r.data[7:0];
      end
   end

   // sticky status, cleared by read; set beats clear
   logic rd_stat;
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         sts_r <= 2'b00;
         mask_r <= 2'b00;
      end else begin
         if (wfire && lane0 && hit(wreq_r.addr, `PFBW_OFF_MASK)) mask_r <= wreq_r.data[1:0];
         // only completion sets the done flag
         sts_r[`PFBW_ST_DONE] <= (sts_r[`PFBW_ST_DONE] && !rd_stat) || state_r == PFBW_DONE;
         sts_r[`PFBW_ST_ERR] <= (sts_r[`PFBW_ST_ERR] && !rd_stat)
            || (state_r == PFBW_IDLE && go && bad_addr);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) IRQ <= 1'b0;
      else IRQ <= |(sts_r & mask_r);
   end

   // read channel
   assign rd_stat = S_AXI_ARVALID && S_AXI_ARREADY && hit(S_AXI_ARADDR, `PFBW_OFF_STAT);
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= `PFBW_RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP <= known(S_AXI_ARADDR) ? `PFBW_RESP_OKAY : `PFBW_RESP_SLVERR;
         S_AXI_RDATA <= 32'h0000_0000;
         if (hit(S_AXI_ARADDR, `PFBW_OFF_CTRL))
            S_AXI_RDATA[3:0] <= {write_error_flag_r, pmem_sel_r, write_enable_bit_r, wr_r};
         else if (hit(S_AXI_ARADDR, `PFBW_OFF_PTR))
            S_AXI_RDATA[PTR_W-1:0] <= table_pointer_r;
         else if (hit(S_AXI_ARADDR, `PFBW_OFF_LATCH))
            S_AXI_RDATA[7:0] <= latch_r[table_pointer_r[LW-1:0]];
         else if (hit(S_AXI_ARADDR, `PFBW_OFF_STAT))
            S_AXI_RDATA[1:0] <= sts_r;
         else if (hit(S_AXI_ARADDR, `PFBW_OFF_MASK))
            S_AXI_RDATA[1:0] <= mask_r;
         else if (hit(S_AXI_ARADDR, `PFBW_OFF_PROT))
            S_AXI_RDATA[PTR_W-1:0] <= prot_base_r;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end
   end

   a_err_no_prog: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_r == PFBW_IDLE && go && bad_addr) |=> !CORE_HOLD && !wr_r && write_error_flag_r)
      else $error("protected start did not refuse");
   a_hold_in_prog: assert property (@(posedge CORE_CLK) disable iff (RST)
      timer_start |=> CORE_HOLD [*2])
      else $error("core not held at write start");
   a_done_sets: assert property (@(posedge CORE_CLK) disable iff (RST)
      state_r == PFBW_DONE |=> sts_r[`PFBW_ST_DONE] && !wr_r && !CORE_HOLD)
      else $error("completion did not set done");
   a_latch_reset: assert property (@(posedge CORE_CLK) disable iff (RST)
      state_r == PFBW_DONE |=> latch_r[0] == `PFBW_LATCH_RST)
      else $error("latch not reset after write");
   a_write_enable_bit_kept: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_r == PFBW_DONE && !wr_ctrl) |=> write_enable_bit_r == $past(write_enable_bit_r))
      else $error("enable bit changed on completion");
   a_load_noflag: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr_latch && state_r == PFBW_IDLE && !rd_stat) |=> $stable(sts_r[`PFBW_ST_DONE]))
      else $error("latch load changed done flag");
   a_load_protect: assert property (@(posedge CORE_CLK) disable iff (RST)
      (wr_latch && state_r == PFBW_IDLE && bad_addr && table_pointer_r[LW-1:0] == '0)
      |=> latch_r[0] == $past(wreq_r.data[7:0]))
      else $error("latch load blocked");
   a_ff_no_we: assert property (@(posedge CORE_CLK) disable iff (RST)
      FLASH_WE |-> FLASH_DATA != `PFBW_LATCH_RST)
      else $error("erased byte strobed");
   a_irq_mask: assert property (@(posedge CORE_CLK) disable iff (RST)
      (sts_r[`PFBW_ST_DONE] && mask_r[`PFBW_ST_DONE]) |=> IRQ)
      else $error("masked-in done gave no irq");
   a_irq_off: assert property (@(posedge CORE_CLK) disable iff (RST)
      !(|(sts_r & mask_r)) |=> !IRQ)
      else $error("irq without unmasked status");
   a_hold_ends: assert property (@(posedge CORE_CLK) disable iff (RST)
      timer_done |=> !CORE_HOLD)
      else $error("core still held after programming");
   a_we_in_prog: assert property (@(posedge CORE_CLK) disable iff (RST)
      FLASH_WE |-> state_r == PFBW_PROG)
      else $error("flash strobe outside block write");
   a_latch_rst: assert property (@(posedge CORE_CLK)
      RST |=> latch_r[0] == `PFBW_LATCH_RST && latch_r[BLOCK_BYTES-1] == `PFBW_LATCH_RST)
      else $error("latch not ones after reset");
endmodule

// [pfbw_flash_model.sv]
// flash array model behind the programming port
module pfbw_flash_model
   import pfbw_pkg::*;
#(
   parameter int PTR_W = 16
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [PTR_W-1:0] addr,
   input wire logic [7:0] data
);
   logic [7:0] mem [0:(1<<PTR_W)-1];
   int n_prog = 0;

   // erased array reads all ones
   initial foreach (mem[i]) mem[i] = 8'hFF;

   always @(posedge clk) begin
      if (we === 1'b1) begin
         mem[addr] <= mem[addr] & data;
         n_prog <= n_prog + 1;
      end
   end
endmodule

// [program_flash_block_writer_bench.sv]
// self-checking bench for the program flash block writer
`include "pfbw_defs.svh"
module program_flash_block_writer_bench import pfbw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PROG = 8;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic [1:0] resp;
   } pfbw_row_t;
   localparam pfbw_row_t ROWS [5] = '{
      '{`PFBW_OFF_MASK, 32'h0000_0001, `PFBW_RESP_OKAY},
      '{`PFBW_OFF_PROT, 32'h0000_0100, `PFBW_RESP_OKAY},
      '{`PFBW_OFF_PTR, 32'h0000_0200, `PFBW_RESP_OKAY},
      '{12'h01C, 32'h0000_0001, `PFBW_RESP_SLVERR},
      '{12'hFFC, 32'h0000_0001, `PFBW_RESP_SLVERR}};
   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, hold, fwe, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [15:0] faddr;
   logic [7:0] fdata;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   int hold_cyc = 0;

   pfbw_top #(.BLOCK_BYTES(4), .PTR_W(16), .PROG_CYC(PROG)) dut (
      .CORE_CLK(clk), .RST(rst),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CORE_HOLD(hold),
      .FLASH_WE(fwe), .FLASH_ADDR(faddr), .FLASH_DATA(fdata), .IRQ(irq));

   pfbw_flash_model #(.PTR_W(16)) fl (.clk(clk), .we(fwe), .addr(faddr), .data(fdata));

   // free running clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // cycle count for timeout and hold length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (hold === 1'b1) hold_cyc <= hold_cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         results();
      end
   end

   task automatic results();
      $display("counts: %0d compares, %0d mismatches", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one write, both channels offered together
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic wok(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk(r, `PFBW_RESP_OKAY);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, exp);
   endtask

   task automatic ld(input logic [15:0] p, input logic [7:0] b);
      wok(`PFBW_OFF_PTR, {16'h0000, p});
      wok(`PFBW_OFF_LATCH, {24'h00_0000, b});
   endtask

   task automatic start_prog();
      hold_cyc = 0;
      wok(`PFBW_OFF_CTRL, 32'h0000_0006);
      wok(`PFBW_OFF_UNLOCK, 32'h0000_0055);
      wok(`PFBW_OFF_UNLOCK, 32'h0000_00AA);
   endtask

   task automatic wait_prog();
      while (hold_cyc == 0 || hold !== 1'b0) @(posedge clk);
      chk(hold_cyc, PROG);
      repeat (2) @(posedge clk);
   endtask

   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      rst = 1'b1;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0000_0000;
      wstrb = 4'hF;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(hold, 1'b0);
      chk(irq, 1'b0);
      $display("test reset done");
      foreach (ROWS[i]) begin
         wr(ROWS[i].addr, ROWS[i].data, r);
         chk(r, ROWS[i].resp);
      end
      rchk(`PFBW_OFF_MASK, 32'h0000_0001);
      rd(12'h01C, d, r);
      chk(r, `PFBW_RESP_SLVERR);
      $display("test register rows done");
      ld(16'h0200, 8'h12);
      ld(16'h0202, 8'h00);
      start_prog();
      wait_prog();
      chk(fl.mem[16'h0200], 8'h12);
      chk(fl.mem[16'h0201], 8'hFF);
      chk(fl.mem[16'h0202], 8'h00);
      chk(fl.n_prog, 2);
      chk(irq, 1'b1);
      rchk(`PFBW_OFF_CTRL, 32'h0000_0006);
      ld(16'h0201, 8'hFF);
      rchk(`PFBW_OFF_STAT, 32'h0000_0001);
      rchk(`PFBW_OFF_STAT, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      $display("test block write done");
      start_prog();
      wait_prog();
      chk(fl.n_prog, 2);
      rchk(`PFBW_OFF_STAT, 32'h0000_0001);
      $display("test latch reset done");
      ld(16'h0010, 8'h00);
      start_prog();
      repeat (4) @(posedge clk);
      chk(hold, 1'b0);
      rchk(`PFBW_OFF_CTRL, 32'h0000_000E);
      rchk(`PFBW_OFF_STAT, 32'h0000_0002);
      chk(fl.n_prog, 2);
      chk(irq, 1'b0);
      $display("test protected write done");
      // mid-run reset returns latches to ones
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(hold, 1'b0);
      chk(irq, 1'b0);
      rchk(`PFBW_OFF_LATCH, 32'h0000_00FF);
      rchk(`PFBW_OFF_STAT, 32'h0000_0000);
      $display("test mid-run reset done");
      results();
   end
endmodule
